// ---- common/uart_pkg.sv ----
package uart_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned CLK_KHZ = 1000000 / CLK_PERIOD_NS;
  localparam int unsigned ACC_W = 18;
  localparam int unsigned DIV_W = 16;
  localparam int unsigned DIV_FRAC_BITS = 3;
  localparam logic [16:0] DIV_ONE = 17'h00008;

  // ****************************************
  // fifo
  // ****************************************
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned FIFO_WIDTH = 8;
  localparam int unsigned CNT_W = 3;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_DIV = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_PINSEL = 8'h14;

  // status layout: rx count, tx count, sticky events
  localparam int unsigned ST_RXCNT_LSB = 0;
  localparam int unsigned ST_TXCNT_LSB = 4;
  localparam int unsigned ST_EVT_LSB = 8;
  localparam int unsigned EVT_W = 5;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    PAR_ODD,
    PAR_EVEN,
    PAR_MARK,
    PAR_SPACE
  } par_t;

  // ctrl register bits 7..0, from msb: clk_sel, flow_en, stop2, par_type, par_en, len8
  typedef struct packed {
    logic [1:0] clk_sel;
    logic flow_en;
    logic stop2;
    par_t par_type;
    logic par_en;
    logic len8;
  } ctrl_t;

  typedef struct packed {
    logic overrun;
    logic frame_err;
    logic parity_err;
    logic tx_done;
    logic rx_ready;
  } evt_t;

  localparam ctrl_t CTRL_RST = '{clk_sel: 2'h0, flow_en: 1'b1, stop2: 1'b0,
                                 par_type: PAR_ODD, par_en: 1'b0, len8: 1'b1};
  localparam logic [15:0] DIV_RST = 16'h0080;
  localparam logic [4:0] MASK_RST = 5'h00;
  localparam logic PINSEL_RST = 1'b0;

  // input clock rate in kHz for each selector setting
  function automatic logic [ACC_W-1:0] clk_khz(input logic radio, input logic [1:0] sel);
    logic [ACC_W-1:0] f;
    f = 18'h00000;
    unique case (sel)
      2'h0: f = radio ? 18'h19640 : 18'h02710;
      2'h1: f = radio ? 18'h0cb20 : 18'h01388;
      2'h2: f = radio ? 18'h06590 : 18'h009c4;
      2'h3: f = radio ? 18'h032c8 : 18'h004e2;
    endcase
    return f;
  endfunction

  // parity bit for a character under the chosen scheme
  function automatic logic par_bit(input logic [7:0] d, input par_t t);
    logic p;
    p = 1'b0;
    unique case (t)
      PAR_ODD: p = ~^d;
      PAR_EVEN: p = ^d;
      PAR_MARK: p = 1'b1;
      PAR_SPACE: p = 1'b0;
    endcase
    return p;
  endfunction

endpackage

// ---- core/uart_fifo.sv ----
`timescale 1ns/100ps

module uart_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic [W-1:0] din,
  input wire logic pop,
  output logic [W-1:0] dout,
  output logic full,
  output logic empty,
  output logic [$clog2(D):0] count
);

  localparam int unsigned PW = $clog2(D);

  logic [W-1:0] mem_r [D];
  logic [W-1:0] mem_nxt [D];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [PW:0] cnt_r, cnt_nxt;
  logic do_push, do_pop;

  assign full = (cnt_r == (PW + 1)'(D));
  assign empty = (cnt_r == '0);
  assign dout = mem_r[rp_r];
  assign count = cnt_r;

  // ****************************************
  // pointers and storage
  // ****************************************
  always_comb begin
    do_push = push & ~full;
    do_pop = pop & ~empty;
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (do_push) begin
      mem_nxt[wp_r] = din;
      wp_nxt = wp_r + 1'b1;
    end
    if (do_pop) begin
      rp_nxt = rp_r + 1'b1;
    end
    if (do_push & ~do_pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (do_pop & ~do_push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < D; i++) begin
        mem_r[i] <= '0;
      end
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

endmodule

// ---- core/fractional_baud_uart.sv ----
`timescale 1ns/100ps

// Contract
// - The bit period divider is a 16-bit value of thirteen integer and three fraction bits.
// - The radio-side port picks its input clock among 104, 52, 26 and 13 MHz.
// - The wireless LAN port picks its input clock among 10, 5, 2.5 and 1.25 MHz.
// - A character carries seven or eight data bits.
// - Parity is optional and, when on, is odd, even, mark or space.
// - A frame ends with one or two stop bits.
// - Receive and transmit each buffer four characters of eight bits.
// - Status shows the receive fill count and the receive error conditions.
// - Fill and error events can raise an interrupt.
// - In the four-wire variant request-to-send is always driven, and clear-to-send gates transmission while flow_en is set (its reset value).
// - The two-wire variant has only data lines; the four-wire one adds the handshake lines.
// - The port is data terminal equipment: it drives transmit data and request-to-send, and samples the others.
// - The port's signals may be placed on one of two alternative pin locations.
module fractional_baud_uart #(
  parameter bit RADIO_PORT = 1'b1,
  parameter bit FOUR_WIRE = 1'b1
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic IRQ,
  output logic [1:0] TXD_O,
  output logic [1:0] TXD_OE,
  input wire logic [1:0] RXD_I,
  output logic [1:0] RTS_N_O,
  output logic [1:0] RTS_N_OE,
  input wire logic [1:0] CTS_N_I
);

  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} line_state_t;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] din, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = din[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  uart_pkg::ctrl_t ctrl_r, ctrl_nxt;
  logic [uart_pkg::DIV_W-1:0] div_r, div_nxt;
  logic [uart_pkg::EVT_W-1:0] mask_r, mask_nxt;
  uart_pkg::evt_t evt_r, evt_nxt, evt_in;
  logic pinsel_r, pinsel_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic irq_r, irq_nxt;
  logic req, wr, rd;
  logic [31:0] merged;

  logic [uart_pkg::ACC_W-1:0] fin_acc_r, fin_acc_nxt;
  logic [uart_pkg::ACC_W:0] fin_sum;
  logic fin_tick;

  line_state_t tx_st_r, tx_st_nxt;
  logic [16:0] tx_acc_r, tx_acc_nxt, tx_sum;
  logic [7:0] tx_sh_r, tx_sh_nxt;
  logic [2:0] tx_cnt_r, tx_cnt_nxt;
  logic tx_line_r, tx_line_nxt, tx_par_r, tx_par_nxt, tx_end, tx_pop;

  line_state_t rx_st_r, rx_st_nxt;
  logic [16:0] rx_acc_r, rx_acc_nxt, rx_sum;
  logic [7:0] rx_sh_r, rx_sh_nxt, rx_word;
  logic [2:0] rx_cnt_r, rx_cnt_nxt;
  logic rx_perr_r, rx_perr_nxt, rx_smp, rx_push;
  logic rts_n_r, rts_n_nxt;

  logic rxd, cts_ok, tx_push, rx_pop;
  logic [7:0] txf_dout, rxf_dout;
  logic txf_full, txf_empty, rxf_full, rxf_empty;
  logic [uart_pkg::CNT_W-1:0] txf_cnt, rxf_cnt;

  // ****************************************
  // pin location select
  // ****************************************
  assign rxd = RXD_I[pinsel_r];
  assign cts_ok = ~(FOUR_WIRE & ctrl_r.flow_en) | ~CTS_N_I[pinsel_r];

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      TXD_O[i] = (pinsel_r == i[0]) ? tx_line_r : 1'b1;
      TXD_OE[i] = (pinsel_r == i[0]);
      RTS_N_O[i] = (pinsel_r == i[0]) ? rts_n_r : 1'b1;
      RTS_N_OE[i] = FOUR_WIRE & (pinsel_r == i[0]);
    end
  end

  // ****************************************
  // fifos
  // ****************************************
  uart_fifo #(.W(uart_pkg::FIFO_WIDTH), .D(uart_pkg::FIFO_DEPTH)) tx_fifo (
    .clk(CLK),
    .rst_n(RST_N),
    .push(tx_push),
    .din(DAT_I[7:0]),
    .pop(tx_pop),
    .dout(txf_dout),
    .full(txf_full),
    .empty(txf_empty),
    .count(txf_cnt)
  );

  uart_fifo #(.W(uart_pkg::FIFO_WIDTH), .D(uart_pkg::FIFO_DEPTH)) rx_fifo (
    .clk(CLK),
    .rst_n(RST_N),
    .push(rx_push),
    .din(rx_word),
    .pop(rx_pop),
    .dout(rxf_dout),
    .full(rxf_full),
    .empty(rxf_empty),
    .count(rxf_cnt)
  );

  // ****************************************
  // wishbone slave and registers
  // ****************************************
  always_comb begin
    req = CYC_I & STB_I & ~ack_r;
    wr = req & WE_I;
    rd = req & ~WE_I;
    ack_nxt = req;
    dat_nxt = dat_r;
    ctrl_nxt = ctrl_r;
    div_nxt = div_r;
    mask_nxt = mask_r;
    pinsel_nxt = pinsel_r;
    merged = 32'h00000000;
    tx_push = wr & (ADR_I == uart_pkg::ADDR_DATA) & SEL_I[0];
    rx_pop = rd & (ADR_I == uart_pkg::ADDR_DATA);
    if (wr) begin
      unique case (ADR_I)
        uart_pkg::ADDR_CTRL: begin
          merged = wmerge({24'h000000, ctrl_r}, DAT_I, SEL_I);
          ctrl_nxt = merged[7:0];
        end
        uart_pkg::ADDR_DIV: begin
          merged = wmerge({16'h0000, div_r}, DAT_I, SEL_I);
          div_nxt = merged[15:0];
        end
        uart_pkg::ADDR_MASK: begin
          merged = wmerge({19'h00000, mask_r, 8'h00}, DAT_I, SEL_I);
          mask_nxt = merged[uart_pkg::ST_EVT_LSB +: uart_pkg::EVT_W];
        end
        uart_pkg::ADDR_PINSEL: begin
          merged = wmerge({31'h00000000, pinsel_r}, DAT_I, SEL_I);
          pinsel_nxt = merged[0];
        end
        default: begin
          merged = 32'h00000000;
        end
      endcase
    end
    if (rd) begin
      unique case (ADR_I)
        uart_pkg::ADDR_DATA: dat_nxt = {24'h000000, rxf_dout};
        uart_pkg::ADDR_CTRL: dat_nxt = {24'h000000, ctrl_r};
        uart_pkg::ADDR_DIV: dat_nxt = {16'h0000, div_r};
        uart_pkg::ADDR_STATUS: dat_nxt = {19'h00000, evt_r, 1'b0, txf_cnt, 1'b0, rxf_cnt};
        uart_pkg::ADDR_MASK: dat_nxt = {19'h00000, mask_r, 8'h00};
        uart_pkg::ADDR_PINSEL: dat_nxt = {31'h00000000, pinsel_r};
        default: dat_nxt = 32'h00000000;
      endcase
    end
    // read of status clears, but a new event in the same cycle survives
    evt_nxt = (rd && ADR_I == uart_pkg::ADDR_STATUS) ? '0 : evt_r;
    evt_nxt = evt_nxt | evt_in;
    irq_nxt = |(evt_nxt & mask_nxt);
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
      ctrl_r <= uart_pkg::CTRL_RST;
      div_r <= uart_pkg::DIV_RST;
      mask_r <= uart_pkg::MASK_RST;
      pinsel_r <= uart_pkg::PINSEL_RST;
      evt_r <= '0;
      irq_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      ctrl_r <= ctrl_nxt;
      div_r <= div_nxt;
      mask_r <= mask_nxt;
      pinsel_r <= pinsel_nxt;
      evt_r <= evt_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign ACK_O = ack_r;
  assign DAT_O = dat_r;
  assign IRQ = irq_r;

  // ****************************************
  // selected input clock as a tick train
  // ****************************************
  always_comb begin
    fin_sum = {1'b0, fin_acc_r} + {1'b0, uart_pkg::clk_khz(RADIO_PORT, ctrl_r.clk_sel)};
    fin_tick = (fin_sum >= (uart_pkg::ACC_W + 1)'(uart_pkg::CLK_KHZ));
    fin_acc_nxt = fin_tick ? uart_pkg::ACC_W'(fin_sum - (uart_pkg::ACC_W + 1)'(uart_pkg::CLK_KHZ))
                           : uart_pkg::ACC_W'(fin_sum);
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      fin_acc_r <= '0;
    end else begin
      fin_acc_r <= fin_acc_nxt;
    end
  end

  // ****************************************
  // transmitter
  // ****************************************
  always_comb begin
    // accumulator in eighths of an input clock: bit ends when it reaches the divider
    tx_sum = tx_acc_r + uart_pkg::DIV_ONE;
    tx_end = fin_tick & (tx_sum >= {1'b0, div_r});
    tx_st_nxt = tx_st_r;
    tx_acc_nxt = tx_acc_r;
    tx_sh_nxt = tx_sh_r;
    tx_cnt_nxt = tx_cnt_r;
    tx_line_nxt = tx_line_r;
    tx_par_nxt = tx_par_r;
    tx_pop = 1'b0;
    if (tx_st_r != S_IDLE && fin_tick) begin
      tx_acc_nxt = tx_end ? (tx_sum - {1'b0, div_r}) : tx_sum;
    end
    unique case (tx_st_r)
      S_IDLE: begin
        tx_line_nxt = 1'b1;
        if (!txf_empty && cts_ok) begin
          tx_pop = 1'b1;
          tx_sh_nxt = ctrl_r.len8 ? txf_dout : {1'b0, txf_dout[6:0]};
          tx_par_nxt = uart_pkg::par_bit(ctrl_r.len8 ? txf_dout : {1'b0, txf_dout[6:0]}, ctrl_r.par_type);
          tx_acc_nxt = '0;
          tx_line_nxt = 1'b0;
          tx_st_nxt = S_START;
        end
      end
      S_START: begin
        if (tx_end) begin
          tx_line_nxt = tx_sh_r[0];
          tx_cnt_nxt = 3'h0;
          tx_st_nxt = S_DATA;
        end
      end
      S_DATA: begin
        if (tx_end) begin
          tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
          tx_cnt_nxt = tx_cnt_r + 3'h1;
          tx_line_nxt = tx_sh_r[1];
          if (tx_cnt_r == (ctrl_r.len8 ? 3'h7 : 3'h6)) begin
            tx_cnt_nxt = 3'h0;
            tx_line_nxt = ctrl_r.par_en ? tx_par_r : 1'b1;
            tx_st_nxt = ctrl_r.par_en ? S_PAR : S_STOP;
          end
        end
      end
      S_PAR: begin
        if (tx_end) begin
          tx_line_nxt = 1'b1;
          tx_st_nxt = S_STOP;
        end
      end
      S_STOP: begin
        if (tx_end) begin
          if (ctrl_r.stop2 && tx_cnt_r == 3'h0) begin
            tx_cnt_nxt = 3'h1;
          end else begin
            tx_st_nxt = S_IDLE;
          end
        end
      end
      default: begin
        tx_st_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_st_r <= S_IDLE;
      tx_acc_r <= '0;
      tx_sh_r <= 8'h00;
      tx_cnt_r <= 3'h0;
      tx_line_r <= 1'b1;
      tx_par_r <= 1'b0;
    end else begin
      tx_st_r <= tx_st_nxt;
      tx_acc_r <= tx_acc_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_line_r <= tx_line_nxt;
      tx_par_r <= tx_par_nxt;
    end
  end

  // ****************************************
  // receiver
  // ****************************************
  always_comb begin
    rx_word = ctrl_r.len8 ? rx_sh_r : {1'b0, rx_sh_r[7:1]};
    rx_sum = rx_acc_r + uart_pkg::DIV_ONE;
    rx_smp = fin_tick & (rx_sum >= {1'b0, div_r});
    rx_st_nxt = rx_st_r;
    rx_acc_nxt = rx_acc_r;
    rx_sh_nxt = rx_sh_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_perr_nxt = rx_perr_r;
    rx_push = 1'b0;
    evt_in = '0;
    evt_in.tx_done = tx_st_r == S_STOP && tx_st_nxt == S_IDLE;
    if (rx_st_r != S_IDLE && fin_tick) begin
      rx_acc_nxt = rx_smp ? (rx_sum - {1'b0, div_r}) : rx_sum;
    end
    unique case (rx_st_r)
      S_IDLE: begin
        if (!rxd) begin
          // start half a bit ahead so samples land mid-bit
          rx_acc_nxt = {2'b00, div_r[15:1]};
          rx_perr_nxt = 1'b0;
          rx_st_nxt = S_START;
        end
      end
      S_START: begin
        if (rx_smp) begin
          rx_cnt_nxt = 3'h0;
          rx_st_nxt = rxd ? S_IDLE : S_DATA;
        end
      end
      S_DATA: begin
        if (rx_smp) begin
          rx_sh_nxt = {rxd, rx_sh_r[7:1]};
          rx_cnt_nxt = rx_cnt_r + 3'h1;
          if (rx_cnt_r == (ctrl_r.len8 ? 3'h7 : 3'h6)) begin
            rx_st_nxt = ctrl_r.par_en ? S_PAR : S_STOP;
          end
        end
      end
      S_PAR: begin
        if (rx_smp) begin
          rx_perr_nxt = rxd != uart_pkg::par_bit(rx_word, ctrl_r.par_type);
          rx_st_nxt = S_STOP;
        end
      end
      S_STOP: begin
        if (rx_smp) begin
          rx_push = 1'b1;
          evt_in.rx_ready = ~rxf_full;
          evt_in.overrun = rxf_full;
          evt_in.frame_err = ~rxd;
          evt_in.parity_err = rx_perr_r;
          rx_st_nxt = S_IDLE;
        end
      end
      default: begin
        rx_st_nxt = S_IDLE;
      end
    endcase
    // full buffer, or one char about to fill it, holds the sender off
    rts_n_nxt = rxf_full | ((rxf_cnt == 3'h3) & rx_push & ~rx_pop);
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_st_r <= S_IDLE;
      rx_acc_r <= '0;
      rx_sh_r <= 8'h00;
      rx_cnt_r <= 3'h0;
      rx_perr_r <= 1'b0;
      rts_n_r <= 1'b0;
    end else begin
      rx_st_r <= rx_st_nxt;
      rx_acc_r <= rx_acc_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_perr_r <= rx_perr_nxt;
      rts_n_r <= rts_n_nxt;
    end
  end

endmodule

// ---- verification/uart_sva.sv ----
`timescale 1ns/100ps
module uart_sva (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  input wire logic IRQ,
  input wire logic [1:0] TXD_O,
  input wire logic [1:0] TXD_OE,
  input wire logic [1:0] RTS_N_O,
  input wire logic [1:0] RTS_N_OE,
  input wire logic [1:0] CTS_N_I
);
  // ****
  // bus and line relations
  // ****
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire logic tx_line = |(TXD_O & TXD_OE);
  wire logic cts_off = |(CTS_N_I & TXD_OE);
  sequence req_taken;
    CYC_I && STB_I && !ACK_O;
  endsequence
  // clear-to-send has been off long enough for any input sync to settle
  sequence cts_off_idle;
    cts_off[*5] ##0 tx_line;
  endsequence
  chk_ack_next: assert property (req_taken |=> ACK_O) else $error("no ack after request");
  chk_ack_pulse: assert property (ACK_O |=> !ACK_O) else $error("ack longer than one cycle");
  chk_irq_drop: assert property ($fell(IRQ) |-> ACK_O)
    else $error("irq fell without bus access");
  chk_tx_unsel: assert property ((TXD_O | TXD_OE) == 2'b11) else $error("unselected tx not high");
  chk_loc_onehot: assert property ($onehot(TXD_OE) && RTS_N_OE == TXD_OE)
    else $error("pin location enables wrong");
  chk_rts_unsel: assert property ((RTS_N_O | RTS_N_OE) == 2'b11) else $error("unselected rts low");
  chk_unmapped_zero: assert property (ACK_O && !$past(WE_I) && $past(ADR_I) > 8'h17 |-> DAT_O == 32'h0)
    else $error("unmapped read not zero");
  chk_fill_limit: assert property (ACK_O && !$past(WE_I) && $past(ADR_I) == uart_pkg::ADDR_STATUS
    |-> DAT_O[2:0] <= 3'h4 && DAT_O[6:4] <= 3'h4) else $error("fill count above depth");
  chk_cts_hold: assert property (cts_off_idle |=> tx_line) else $error("tx started with cts off");
endmodule
bind fractional_baud_uart uart_sva chk (.CLK(CLK), .RST_N(RST_N), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
  .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .IRQ(IRQ), .TXD_O(TXD_O), .TXD_OE(TXD_OE),
  .RTS_N_O(RTS_N_O), .RTS_N_OE(RTS_N_OE), .CTS_N_I(CTS_N_I));

// ---- verification/host_uart.sv ----
`timescale 1ns/100ps
module host_uart #(
  parameter int BIT = 25
) (
  input wire logic clk,
  input wire uart_pkg::ctrl_t cfg,
  input wire logic txd,
  input wire logic rts_n,
  input wire logic hold,
  output logic rxd,
  output logic cts_n
);
  // ****
  // host side of the link
  // ****
  logic [7:0] got;
  logic gpar;
  logic gstop;
  int nfr = 0;
  int now = 0;
  int t0 = 0;
  int gap = 0;
  assign cts_n = hold;
  always @(posedge clk) now <= now + 1;
  function automatic logic par_of(input logic [7:0] d, input uart_pkg::ctrl_t c);
    if (c.par_type == uart_pkg::PAR_MARK) return 1'b1;
    if (c.par_type == uart_pkg::PAR_SPACE) return 1'b0;
    return (^d) ^ (c.par_type == uart_pkg::PAR_ODD);
  endfunction
  initial begin
    forever begin
      @(negedge txd);
      gap = now - t0;
      t0 = now;
      got = 8'h00;
      gpar = 1'b1;
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 7 + cfg.len8; i++) begin
        repeat (BIT) @(posedge clk);
        got[i] = txd;
      end
      if (cfg.par_en) begin
        repeat (BIT) @(posedge clk);
        gpar = txd;
      end
      repeat (BIT) @(posedge clk);
      gstop = txd;
      nfr++;
    end
  end
  initial rxd = 1'b1;
  task automatic send(input logic [7:0] d, input logic [1:0] bad);
    logic q[$];
    q = {1'b0};
    for (int i = 0; i < 7 + cfg.len8; i++) q.push_back(d[i]);
    if (cfg.par_en) q.push_back(par_of(cfg.len8 ? d : {1'b0, d[6:0]}, cfg) ^ bad[0]);
    q.push_back(~bad[1]);
    if (cfg.stop2) q.push_back(1'b1);
    do @(posedge clk); while (rts_n !== 1'b0);
    foreach (q[i]) begin
      rxd <= q[i];
      repeat (BIT) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask
endmodule

// ---- verification/fractional_baud_uart_bench.sv ----
`timescale 1ns/100ps
module fractional_baud_uart_bench;
  localparam int BIT = 25;
  logic CLK, RST_N, CYC_I, STB_I, WE_I, ACK_O, IRQ, loc, hold;
  logic [7:0] ADR_I, d, m;
  logic [3:0] SEL_I = 4'hf;
  logic [31:0] DAT_I, DAT_O, rd;
  logic [1:0] TXD_O, TXD_OE, RTS_N_O, RTS_N_OE;
  logic [7:0] q [4];
  wire logic p_rxd, p_cts;
  uart_pkg::ctrl_t c, hcfg;
  int n_errors = 0;
  int n_compared = 0;
  int seed = 6593;
  int n, b;
  // unselected locations see a moving line, so a wrong pin mux shows up
  fractional_baud_uart #(.RADIO_PORT(1'b1), .FOUR_WIRE(1'b1)) uut (.CLK(CLK), .RST_N(RST_N), .CYC_I(CYC_I),
    .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .IRQ(IRQ), .TXD_O(TXD_O), .TXD_OE(TXD_OE), .RXD_I(loc ? {p_rxd, ~p_rxd} : {~p_rxd, p_rxd}),
    .RTS_N_O(RTS_N_O), .RTS_N_OE(RTS_N_OE), .CTS_N_I(loc ? {p_cts, ~p_cts} : {~p_cts, p_cts}));
  host_uart #(.BIT(BIT)) host (.clk(CLK), .cfg(hcfg), .txd(TXD_O[loc]), .rts_n(RTS_N_O[loc]), .hold(hold),
    .rxd(p_rxd), .cts_n(p_cts));
  // ****
  // helpers
  // ****
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k;
    k = 0;
    @(posedge CLK);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= w;
    ADR_I <= a;
    DAT_I <= v;
    do begin
      @(posedge CLK);
      k++;
    end while (ACK_O !== 1'b1 && k < 50);
    rd = DAT_O;
    if (k >= 50) check(32'h0, 32'h1);
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic wait_frames(input int f);
    int k;
    k = 0;
    while (host.nfr < f && k < 2000) begin
      @(posedge CLK);
      k++;
    end
    if (k >= 2000) check(32'h0, 32'h1);
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge CLK);
    n_errors++;
    report_and_stop();
  end
  // ****
  // tests
  // ****
  initial begin
    {RST_N, CYC_I, STB_I, WE_I, loc, hold} = 6'h00;
    ADR_I = 8'h00;
    DAT_I = 32'h0;
    hcfg = uart_pkg::CTRL_RST;
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    check({26'h0, TXD_O, TXD_OE, RTS_N_O}, {26'h0, 6'b110110});
    rchk(uart_pkg::ADDR_CTRL, {24'h0, uart_pkg::CTRL_RST});
    rchk(uart_pkg::ADDR_DIV, {16'h0, uart_pkg::DIV_RST});
    rchk(uart_pkg::ADDR_MASK, 32'h0);
    rchk(uart_pkg::ADDR_PINSEL, 32'h0);
    rchk(8'h20, 32'h0);
    wb(1'b1, uart_pkg::ADDR_DIV, 32'h0000ffff);
    rchk(uart_pkg::ADDR_DIV, 32'h0000ffff);
    wb(1'b1, uart_pkg::ADDR_DIV, 32'h00000068);
    $display("test reset done");
    loc <= 1'b1;
    wb(1'b1, uart_pkg::ADDR_PINSEL, 32'h1);
    @(posedge CLK);
    check({30'h0, TXD_OE}, 32'h2);
    for (int i = 0; i < 10; i++) begin
      c = uart_pkg::CTRL_RST;
      c.len8 = i[0];
      c.stop2 = i[1];
      c.par_en = (i < 8);
      c.par_type = uart_pkg::par_t'(i[2:1]);
      hcfg <= c;
      wb(1'b1, uart_pkg::ADDR_CTRL, {24'h0, c});
      d = 8'($random(seed));
      n = host.nfr;
      wb(1'b1, uart_pkg::ADDR_DATA, {24'h0, d});
      wb(1'b1, uart_pkg::ADDR_DATA, {24'h0, ~d});
      wait_frames(n + 2);
      m = c.len8 ? ~d : {1'b0, ~d[6:0]};
      b = 9 + c.len8 + c.par_en + c.stop2;
      check({24'h0, host.got}, {24'h0, m});
      check({31'h0, host.gpar}, {31'h0, c.par_en ? host.par_of(m, c) : 1'b1});
      check({30'h0, host.gstop, host.gap >= b * BIT - 2 && host.gap <= b * BIT + 2}, 32'h3);
    end
    $display("test tx formats done");
    hold <= 1'b1;
    n = host.nfr;
    repeat (8) @(posedge CLK);
    wb(1'b1, uart_pkg::ADDR_DATA, 32'h5a);
    repeat (20 * BIT) @(posedge CLK);
    check(host.nfr, n);
    hold <= 1'b0;
    wait_frames(n + 1);
    check({24'h0, host.got}, 32'h5a);
    $display("test flow hold done");
    loc <= 1'b0;
    wb(1'b1, uart_pkg::ADDR_PINSEL, 32'h0);
    wb(1'b1, uart_pkg::ADDR_CTRL, {24'h0, uart_pkg::CTRL_RST});
    hcfg <= uart_pkg::CTRL_RST;
    repeat (2 * BIT) @(posedge CLK);
    wb(1'b0, uart_pkg::ADDR_STATUS, 32'h0);
    for (int i = 0; i < 4; i++) begin
      q[i] = 8'($random(seed));
      host.send(q[i], 2'b00);
    end
    @(posedge CLK);
    check({30'h0, RTS_N_O[0], IRQ}, 32'h2);
    rchk(uart_pkg::ADDR_STATUS, 32'h00000104);
    for (int i = 0; i < 4; i++) rchk(uart_pkg::ADDR_DATA, {24'h0, q[i]});
    @(posedge CLK);
    check({31'h0, RTS_N_O[0]}, 32'h0);
    $display("test rx fill done");
    c = uart_pkg::CTRL_RST;
    c.len8 = 1'b0;
    c.par_en = 1'b1;
    c.par_type = uart_pkg::PAR_EVEN;
    hcfg <= c;
    wb(1'b1, uart_pkg::ADDR_CTRL, {24'h0, c});
    wb(1'b1, uart_pkg::ADDR_MASK, 32'h00000c00);
    host.send(8'hc5, 2'b01);
    check({31'h0, IRQ}, 32'h1);
    rchk(uart_pkg::ADDR_STATUS, 32'h00000501);
    repeat (2) @(posedge CLK);
    check({31'h0, IRQ}, 32'h0);
    rchk(uart_pkg::ADDR_DATA, 32'h45);
    host.send(8'h33, 2'b10);
    check({31'h0, IRQ}, 32'h1);
    rchk(uart_pkg::ADDR_STATUS, 32'h00000901);
    rchk(uart_pkg::ADDR_DATA, 32'h33);
    $display("test rx errors done");
    report_and_stop();
  end
endmodule
